//--- epp_pin_model.sv
module epp_pin_model (
  input  logic [7:0] pinOut, // Design drive value
  input  logic [7:0] pinOe,  // Design drive enable
  input  logic [7:0] ext,    // Outside source
  output logic [7:0] pinIn   // Resolved level
);
  timeunit 1ns;
  timeprecision 1ps;
  // Undriven pins follow the outside source, never a stale design value
  assign pinIn = (pinOe & pinOut) | (~pinOe & ext);
endmodule // epp_pin_model

//--- epp_port.v
`include "epp_port_map.vh"

// Contract
// - Port is eight bits wide, each pin usable as input or output.
// - Direction bit 1 puts the pin driver in high impedance.
// - Direction bit 0 drives the pin from its output latch bit.
// - Latch register reads and writes return the latch, never pin levels.
// - Each pin has its own direction bit.
// - After reset every pin is a digital input.
// - Slave select bit turns the whole port into a host data port; pins 5 to 7 with direction 0 and an active PWM channel still carry PWM.
// - Slave mode selects TTL input thresholds instead of Schmitt.
// - Dual or quad PWM output mode disables slave port functions.
// - In slave mode pins output latch as host read data.
// - In slave mode host write data enters via TTL input.
// - Pins 5 to 7 carry PWM B, C, D when direction is 0.
// - PWM outputs on these pins may tri-state on shutdown.
// - Port exists only in larger package variants.
// - Slave select at bit 4 of neighbour direction register, reset 0.
module epp_port #(
  parameter PORT_PRESENT = 1,              // 0 in small packages
  parameter WIDTH        = 8               // Port width
) (
  input  wire             mclk,            // Core clock, 20 MHz
  input  wire             resetn,          // Async reset, active low
  input  wire             psel,            // APB select
  input  wire             penable,         // APB enable
  input  wire             pwrite,          // APB direction
  input  wire [7:0]       paddr,           // APB byte address
  input  wire [31:0]      pwdata,          // APB write data
  output reg  [31:0]      prdata,          // APB read data
  output reg              pready,          // APB ready
  output reg              pslverr,         // APB error, unmapped address
  input  wire [WIDTH-1:0] pinIn,           // Pin levels
  output reg  [WIDTH-1:0] pinOut,          // Pin drive values
  output reg  [WIDTH-1:0] pinOe,           // Pin drive enables, high drives
  output reg              ttlSelect,       // High: TTL input thresholds
  input  wire             hostRead,        // Host read strobe, level
  input  wire             hostWrite,       // Host write strobe, pulse
  output reg  [WIDTH-1:0] hostWriteData,   // Last host write byte
  input  wire             pwmMultiOut,     // PWM in dual or quad mode
  input  wire [2:0]       pwmChanEn,       // PWM B, C, D active
  input  wire [2:0]       pwmChan,         // PWM B, C, D levels
  input  wire             pwmShutdown      // PWM shutdown event, level
);

  localparam PRESENT = (PORT_PRESENT != 0);

  reg  [WIDTH-1:0] portOutputLatch;
  reg  [WIDTH-1:0] portDirectionBits;
  reg  [7:0]       neighbourDirectionReg;
  reg  [7:0]       pwmConfig;
  reg  [WIDTH-1:0] portPinLevels;
  reg  [WIDTH-1:0] next_pinOut;
  reg  [WIDTH-1:0] next_pinOe;
  reg  [31:0]      next_prdata;
  reg              next_pslverr;
  wire             hostTake;
  wire             slaveSel;
  wire             slaveActive;
  wire             triOnShutdown;
  wire             setupRead;
  wire             accessWrite;
  integer          i;
  wire             wrLatch;
  wire             wrDir;
  wire             wrNbdir;
  wire             wrPwmCfg;
  wire [WIDTH-1:0] pwmEnAtPin;
  wire [WIDTH-1:0] pwmValAtPin;
  wire [WIDTH-1:0] pwmOeAtPin;
  reg  [WIDTH-1:0] portLayerOut;
  reg  [WIDTH-1:0] portLayerOe;
  reg  [WIDTH-1:0] slaveLayerOut;
  reg  [WIDTH-1:0] slaveLayerOe;

  // Byte into the low bits of a bus word
  function [31:0] zext;
    input [WIDTH-1:0] v;
    begin
      zext = 32'h00000000;
      zext[WIDTH-1:0] = v;
    end
  endfunction

  // Is this pin one of the PWM channel pins
  function isPwmPin;
    input integer idx;
    begin
      isPwmPin = (idx >= `EPP_PWM_LOW_PIN) &&
                 (idx < `EPP_PWM_LOW_PIN + 3);
    end
  endfunction

  // Spread a three-channel PWM vector onto its pins
  function [WIDTH-1:0] atPwmPins;
    input [2:0] chan;
    integer p;
    begin
      atPwmPins = {WIDTH{1'b0}};
      // Pins outside the PWM group never take a channel
      for (p = 0; p < WIDTH; p = p + 1) begin
        if (isPwmPin(p)) begin
          atPwmPins[p] = chan[p - `EPP_PWM_LOW_PIN];
        end
      end
    end
  endfunction

  // Offsets that answer without error; none in the small package
  function isMapped;
    input [7:0] ofs;
    begin
      case (ofs)
        `EPP_PINS_OFS, `EPP_LATCH_OFS, `EPP_DIR_OFS,
        `EPP_NBDIR_OFS, `EPP_PWMCFG_OFS, `EPP_HOSTDAT_OFS: begin
          isMapped = PRESENT;
        end
        default: begin
          isMapped = 1'b0;
        end
      endcase
    end
  endfunction

  // Write strobe for one register offset
  function isWriteTo;
    input [7:0] ofs;
    begin
      isWriteTo = accessWrite && (paddr == ofs) && isMapped(ofs);
    end
  endfunction

  assign slaveSel      = neighbourDirectionReg[`EPP_SLAVE_SEL_BIT];
  // PWM dual/quad wins over the slave port
  assign slaveActive   = slaveSel & ~pwmMultiOut;
  assign triOnShutdown = pwmConfig[`EPP_TRI_EN_BIT];
  assign setupRead     = psel & ~penable;
  // Writes land only at the access edge where pready is seen high
  assign accessWrite   = psel & penable & pready & pwrite;
  // Host bytes are taken only while the slave port owns the pins
  assign hostTake      = hostWrite & slaveActive & PRESENT;
  // Register write strobes, one per writable offset
  assign wrLatch       = isWriteTo(`EPP_LATCH_OFS);
  assign wrDir         = isWriteTo(`EPP_DIR_OFS);
  assign wrNbdir       = isWriteTo(`EPP_NBDIR_OFS);
  assign wrPwmCfg      = isWriteTo(`EPP_PWMCFG_OFS);
  // PWM takes a pin only while its direction bit is 0
  assign pwmEnAtPin    = atPwmPins(pwmChanEn) & ~portDirectionBits;
  assign pwmValAtPin   = atPwmPins(pwmChan);
  // Released on shutdown only when configured to
  assign pwmOeAtPin    = {WIDTH{~(pwmShutdown & triOnShutdown)}};

  // Pin sampling; inputs are synchronous so one stage suffices
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      portPinLevels <= {WIDTH{1'b0}};
    end else begin
      portPinLevels <= pinIn;
    end
  end

  // Output latch; read-only and unmapped offsets never touch it
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      portOutputLatch <= `EPP_LATCH_RST;
    end else if (wrLatch) begin
      portOutputLatch <= pwdata[WIDTH-1:0];
    end
  end

  // Direction bits, one per pin
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      portDirectionBits <= `EPP_DIR_RST;
    end else if (wrDir) begin
      portDirectionBits <= pwdata[WIDTH-1:0];
    end
  end

  // Only the slave select bit is held here
  // Other neighbour bits belong to the neighbouring port
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      neighbourDirectionReg <= `EPP_NBDIR_RST;
    end else if (wrNbdir) begin
      neighbourDirectionReg <= {3'h0,
        pwdata[`EPP_SLAVE_SEL_BIT], 4'h0};
    end
  end

  // Shutdown tri-state enable
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pwmConfig <= `EPP_PWMCFG_RST;
    end else if (wrPwmCfg) begin
      pwmConfig <= {7'h00, pwdata[`EPP_TRI_EN_BIT]};
    end
  end

  // Host write byte, taken straight off the TTL buffers
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hostWriteData <= `EPP_HOSTDAT_RST;
    end else if (hostTake) begin
      hostWriteData <= pinIn;
    end
  end

  // Register contents by offset; unmapped offsets read 0
  function [31:0] readWord;
    input [7:0] ofs;
    begin
      readWord = 32'h00000000;
      case (ofs)
        `EPP_PINS_OFS: begin
          // Sampled levels, output pins included
          readWord = zext(portPinLevels);
        end
        `EPP_LATCH_OFS: begin
          // Latch, not pins, so read-modify-write is safe
          readWord = zext(portOutputLatch);
        end
        `EPP_DIR_OFS: begin
          readWord = zext(portDirectionBits);
        end
        `EPP_NBDIR_OFS: begin
          readWord = {24'h000000, neighbourDirectionReg};
        end
        `EPP_PWMCFG_OFS: begin
          readWord = {24'h000000, pwmConfig};
        end
        `EPP_HOSTDAT_OFS: begin
          readWord = zext(hostWriteData);
        end
        default: begin
          readWord = 32'h00000000;
        end
      endcase
    end
  endfunction

  // Read decode, registered at the setup edge
  always @* begin
    next_prdata  = PRESENT ? readWord(paddr) : 32'h00000000;
    next_pslverr = ~isMapped(paddr);
  end

  // One wait-free answer: ready in the access cycle
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setupRead;
    end
  end

  // Error flag stands beside ready, only for unmapped offsets
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setupRead & next_pslverr;
    end
  end

  // Read data holds until the next read setup
  // Writes leave the last read data in place
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
    end else if (setupRead && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // Plain port layer
  always @* begin
    portLayerOut = portOutputLatch;
    portLayerOe  = ~portDirectionBits;
  end

  // Slave layer: direction bits ignored, host read drives
  // Host sees whatever software last put in the latch
  always @* begin
    slaveLayerOut = portOutputLatch;
    slaveLayerOe  = {WIDTH{hostRead}};
  end

  // Pin drive priority: PWM, then slave port, then plain port
  always @* begin
    next_pinOut = {WIDTH{1'b0}};
    next_pinOe  = {WIDTH{1'b0}};
    for (i = 0; i < WIDTH; i = i + 1) begin
      // Idle PWM channels hand the pin back to the lower layers
      if (pwmEnAtPin[i]) begin
        next_pinOut[i] = pwmValAtPin[i];
        next_pinOe[i]  = pwmOeAtPin[i];
      end else if (slaveActive) begin
        next_pinOut[i] = slaveLayerOut[i];
        next_pinOe[i]  = slaveLayerOe[i];
      end else begin
        next_pinOut[i] = portLayerOut[i];
        next_pinOe[i]  = portLayerOe[i];
      end
    end
    if (!PRESENT) begin
      next_pinOut = {WIDTH{1'b0}};
      next_pinOe  = {WIDTH{1'b0}};
    end
  end

  // Registered pin drive adds one cycle of latency
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pinOut <= {WIDTH{1'b0}};
    end else begin
      pinOut <= next_pinOut;
    end
  end

  // Enables leave reset low, so every pin floats as an input
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pinOe <= {WIDTH{1'b0}};
    end else begin
      pinOe <= next_pinOe;
    end
  end

  // Threshold select follows the effective slave mode
  // Multi-output PWM drops the thresholds back as well
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ttlSelect <= 1'b0;
    end else begin
      ttlSelect <= slaveActive & PRESENT;
    end
  end

endmodule // epp_port

//--- epp_port_map.vh
`ifndef EPP_PORT_MAP_VH
`define EPP_PORT_MAP_VH

// Register byte offsets
`define EPP_PINS_OFS     8'h00
`define EPP_LATCH_OFS    8'h04
`define EPP_DIR_OFS      8'h08
`define EPP_NBDIR_OFS    8'h0C
`define EPP_PWMCFG_OFS   8'h10
`define EPP_HOSTDAT_OFS  8'h14

// Field positions
`define EPP_SLAVE_SEL_BIT 4
`define EPP_TRI_EN_BIT    0
`define EPP_PWM_LOW_PIN   5

// Reset values
`define EPP_LATCH_RST    8'h00
`define EPP_DIR_RST      8'hFF
`define EPP_NBDIR_RST    8'h00
`define EPP_PWMCFG_RST   8'h00
`define EPP_HOSTDAT_RST  8'h00

`endif

//--- epp_port_properties.sv
module epp_port_props #(parameter WIDTH = 8) (
  input logic mclk, resetn, psel, penable, pwrite, pready, ttlSelect,
  input logic hostRead, hostWrite, pwmMultiOut,
  input logic [31:0] prdata,
  input logic [WIDTH-1:0] pinIn, pinOe, hostWriteData,
  input logic [2:0] pwmChanEn
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // No register write near: slave select cannot change under us
  wire quiet = !(psel && pwrite);
  AST_READY: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_PULSE: assert property (pready |=> !pready)
    else $error("ready held");
  AST_RESET_IN: assert property ($rose(resetn) |-> pinOe == 0)
    else $error("pins driven after reset");
  AST_UPPER: assert property (pready && !pwrite |-> prdata[31:8] == 0)
    else $error("upper read bits set");
  AST_TTL_OFF: assert property (pwmMultiOut |=> !ttlSelect)
    else $error("ttl kept in multi pwm");
  AST_NO_SLAVE: assert property (pwmMultiOut && hostWrite |=>
    $stable(hostWriteData)) else $error("host write taken");
  AST_SLAVE_DRIVE: assert property (ttlSelect && hostRead &&
    !pwmMultiOut && pwmChanEn == 0 && quiet && $past(quiet) |=> &pinOe)
    else $error("slave read not driven");
  AST_HOST_WR: assert property (ttlSelect && hostWrite &&
    !pwmMultiOut && quiet && $past(quiet) |=>
    hostWriteData == $past(pinIn)) else $error("host byte lost");
endmodule // epp_port_props

bind epp_port epp_port_props #(.WIDTH(WIDTH)) epp_port_props_inst (.*);

//--- tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, resetn, psel, penable, pwrite, pready, pslverr, err;
  logic ttlSelect, hostRead, hostWrite, pwmMultiOut, pwmShutdown, slv, cfg;
  logic [7:0] paddr, pinIn, pinOut, pinOe, hostWriteData, ext, lat, dir;
  logic [31:0] pwdata, prdata, r;
  logic [2:0] pwmChanEn, pwmChan;
  integer seed = 32'hBFC59A1C, error_cnt = 0, checks = 0, k;
  always #25 mclk = ~mclk;
  epp_port epp_port_inst (.*);
  epp_pin_model epp_pin_model_inst (.*);
  task automatic chk(input logic [32:0] g, e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge mclk) penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1 && ++n < 20);
    r = prdata;
    err = pslverr;
    if (n >= 20) chk(1, 0);
    {psel, penable} <= 0;
    @(posedge mclk);
  endtask
  task automatic hwr(input logic [7:0] v);
    ext <= v;
    hostWrite <= 1;
    @(posedge mclk) hostWrite <= 0;
    apb(0, 8'h14, 0);
  endtask
  function automatic logic [15:0] expPins();
    logic [7:0] o, e;
    o = lat;
    e = (slv && !pwmMultiOut) ? {8{hostRead}} : ~dir;
    for (int i = 5; i < 8; i++)
      if (!dir[i] && pwmChanEn[i-5]) begin
        o[i] = pwmChan[i-5];
        e[i] = !(cfg && pwmShutdown);
      end
    return {e, o};
  endfunction
  task automatic report_and_stop;
    if (error_cnt == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, hostRead, hostWrite, pwmShutdown} = 0;
    {pwmMultiOut, pwmChanEn, pwmChan, paddr, pwdata, ext} = 0;
    {slv, cfg, resetn} = 0;
    repeat (8) @(posedge mclk);
    resetn <= 1;
    repeat (2) @(posedge mclk);
    chk(pinOe, 0);
    apb(0, 8'h08, 0);
    chk(r, 32'hFF);
    for (k = 0; k < 8; k++) begin
      lat = 8'($random(seed));
      dir = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($random(seed));
      ext <= 8'($random(seed));
      apb(1, 8'h04, {24'hFFFFFF, lat});
      apb(1, 8'h08, {24'h0, dir});
      repeat (2) @(posedge mclk);
      chk({pinOe, pinOut}, expPins());
      apb(0, 8'h04, 0);
      chk(r, lat);
      apb(0, 8'h00, 0);
      chk(r, (dir & ext) | (~dir & lat));
    end
    apb(0, 8'h18, 0);
    chk({err, r}, 33'h100000000);
    apb(1, 8'h0C, 32'hFF);
    slv = 1;
    hostRead <= 1;
    repeat (2) @(posedge mclk);
    chk({ttlSelect, pinOe, pinOut}, {1'b1, expPins()});
    apb(0, 8'h0C, 0);
    chk(r, 32'h10);
    hostRead <= 0;
    @(posedge mclk);
    hwr(8'h5A);
    chk(r, 8'h5A);
    chk(hostWriteData, 8'h5A);
    pwmMultiOut <= 1;
    hwr(8'hC3);
    chk({ttlSelect, r}, 8'h5A);
    chk(hostWriteData, 8'h5A);
    {pwmMultiOut, hostRead} <= 2'b01;
    dir = 8'h1F;
    apb(1, 8'h08, 32'h1F);
    for (k = 0; k < 4; k++) begin
      cfg = k[1];
      apb(1, 8'h10, {31'h0, cfg});
      pwmShutdown <= k[0];
      pwmChanEn <= 3'($random(seed)) | 3'h1;
      pwmChan <= 3'($random(seed));
      repeat (2) @(posedge mclk);
      chk({pinOe, pinOut}, expPins());
    end
    report_and_stop;
  end
  initial begin
    #100000;
    error_cnt++;
    report_and_stop;
  end
endmodule // tb_top
